/* design/drs_consts.vh */
// Constants for the storage refresh scheduler
// Functional notes
// RQ1 - Whole array refreshed within 6.1 ms; the code takes 256 periods of 24 us, 6.144 ms
// RQ2 - Start one partial refresh every 24 us
// RQ3 - One 256-bit group per chip, one half
// RQ4 - Each refresh holds storage for 890 ns; the code holds it for 23 cycles of 40 ns, 920 ns
// RQ5 - Alternate halves on successive refresh operations
// RQ6 - Advance group on each return to half
// RQ7 - No ordinary access during refresh
// RQ8 - Hold access request pending until refresh ends
`ifndef DRS_CONSTS_VH
`define DRS_CONSTS_VH
`define DRS_CLK_MHZ 25
`define DRS_RETAIN_US 6100
`define DRS_PERIOD_NS 24000
`define DRS_BUSY_NS 890
`define DRS_PERIOD_CYC ((`DRS_PERIOD_NS * `DRS_CLK_MHZ) / 1000)
`define DRS_BUSY_CYC ((`DRS_BUSY_NS * `DRS_CLK_MHZ + 999) / 1000)
`define DRS_GROUP_BITS 256
`define DRS_GROUPS 128
`define DRS_GROUP_W 7
`define DRS_CNT_W 10
`endif

/* design/drs_tick_gen.v */
// Periodic one-cycle refresh request enable
`timescale 1ns/1ps
module drs_tick_gen #(
    parameter PERIOD = 600,
    parameter CW = 10
) (
    input wire mclk, // Clock
    input wire rst, // Async reset, active high
    output reg tick // One-cycle pulse per period
);
    reg [CW-1:0] cnt_q;
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= {CW{1'b0}};
            tick <= 1'b0;
        end
        else if (cnt_q == PERIOD[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
        begin
            cnt_q <= {CW{1'b0}};
            tick <= 1'b1; // RQ2
        end
        else
        begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule // drs_tick_gen

/* design/dram_refresh_scheduler.v */
// Refresh scheduler with storage access gating
`timescale 1ns/1ps
`include "drs_consts.vh"
module dram_refresh_scheduler #(
    parameter PERIOD_CYC = `DRS_PERIOD_CYC,
    parameter BUSY_CYC = `DRS_BUSY_CYC,
    parameter GW = `DRS_GROUP_W
) (
    input wire mclk, // 25 MHz clock
    input wire rst, // Async reset, active high
    input wire accReq, // Storage access request level
    input wire accWrite, // Request is a write
    input wire accDone, // Storage reports access finished
    output reg accGrant_q, // Access granted to storage
    output reg accPend_q, // Request held during refresh
    output reg refActive_q, // Refresh in progress
    output reg refHalf_q, // Half being refreshed
    output reg [GW-1:0] refGroup_q, // Group index being refreshed
    output reg refStart_q, // Pulse at refresh start
    output reg memWrite_q // Write strobe to storage
);
    // One-hot controller states
    localparam ST_IDLE = 3'b001;
    localparam ST_ACC = 3'b010;
    localparam ST_REF = 3'b100;

    // Storage halves served in turn
    localparam HALVES = 2;
    localparam integer GRP_LAST_I = `DRS_GROUPS - 1;
    localparam [GW-1:0] GRP_LAST = GRP_LAST_I[GW-1:0];
    localparam [GW-1:0] GRP_ONE = {{(GW-1){1'b0}}, 1'b1};
    localparam [`DRS_CNT_W-1:0] CNT_ONE = {{(`DRS_CNT_W-1){1'b0}}, 1'b1};
    localparam [`DRS_CNT_W-1:0] BUSY_LOAD = BUSY_CYC[`DRS_CNT_W-1:0];

    wire tick;
    wire refDue;
    wire startRef;
    wire startAcc;
    wire accEnd;
    wire busyLast;
    wire refEnd;
    wire [HALVES-1:0] grpStep;
    wire [GW-1:0] grpNow [0:HALVES-1];
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [`DRS_CNT_W-1:0] busy_q;
    reg tickPend_q;

    // Next group index, wrapping after the last group of a half
    function [GW-1:0] nextGroup;
        input [GW-1:0] grp;
        begin
            if (grp == GRP_LAST)
                nextGroup = {GW{1'b0}}; // RQ1
            else
                nextGroup = grp + GRP_ONE;
        end
    endfunction

    // True when the one-hot code holds the wanted state
    function inState;
        input [2:0] cur;
        input [2:0] want;
        begin
            inState = (cur & want) != 3'h0;
        end
    endfunction

    drs_tick_gen #(.PERIOD(PERIOD_CYC), .CW(`DRS_CNT_W)) uTick (
        .mclk(mclk),
        .rst(rst),
        .tick(tick)
    );

    // Events of the controller
    assign refDue = tick | tickPend_q;
    assign busyLast = busy_q == CNT_ONE;
    assign startRef = inState(st_q, ST_IDLE) & refDue;
    assign startAcc = inState(st_q, ST_IDLE) & ~refDue & accReq;
    assign accEnd = inState(st_q, ST_ACC) & accDone;
    assign refEnd = inState(st_q, ST_REF) & busyLast;

    // Group of the half just refreshed moves on
    assign grpStep[0] = refEnd & ~refHalf_q;
    assign grpStep[1] = refEnd & refHalf_q;

    // One group counter per storage half
    genvar h;
    generate
        for (h = 0; h < HALVES; h = h + 1)
        begin : gHalf
            reg [GW-1:0] grp_q;
            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                    grp_q <= {GW{1'b0}};
                else if (grpStep[h])
                    grp_q <= nextGroup(grp_q); // RQ6
            end
            assign grpNow[h] = grp_q;
        end
    endgenerate

    // Refresh wins over a new access; an access is never cut
    always @*
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:
            begin
                if (refDue)
                    st_d = ST_REF;
                else if (accReq)
                    st_d = ST_ACC;
            end
            ST_ACC:
            begin
                if (accDone)
                    st_d = ST_IDLE;
            end
            ST_REF:
            begin
                if (busyLast)
                    st_d = ST_IDLE;
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            st_q <= ST_IDLE;
        else
            st_q <= st_d;
    end

    // Tick seen during an access waits for idle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            tickPend_q <= 1'b0;
        else if (startRef)
            tickPend_q <= 1'b0;
        else if (tick)
            tickPend_q <= 1'b1; // RQ2
    end

    // Cycles left in the refresh
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            busy_q <= {`DRS_CNT_W{1'b0}};
        else if (startRef)
            busy_q <= BUSY_LOAD; // RQ4
        else if (inState(st_q, ST_REF))
            busy_q <= busy_q - CNT_ONE;
    end

    // Grant holds until the array reports the access done
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            accGrant_q <= 1'b0;
        else if (startAcc)
            accGrant_q <= 1'b1;
        else if (accEnd || inState(st_q, ST_REF))
            accGrant_q <= 1'b0; // RQ7
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            memWrite_q <= 1'b0;
        else if (startAcc)
            memWrite_q <= accWrite;
        else if (accEnd)
            memWrite_q <= 1'b0;
    end

    // Held request stays set to the end of the refresh and clears in idle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            accPend_q <= 1'b0;
        else if (startRef)
            accPend_q <= accReq; // RQ8
        else if (inState(st_q, ST_REF))
        begin
            if (accReq)
                accPend_q <= 1'b1; // RQ8
        end
        else if (inState(st_q, ST_IDLE))
            accPend_q <= 1'b0;
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            refActive_q <= 1'b0;
        else if (startRef)
            refActive_q <= 1'b1; // RQ4
        else if (refEnd)
            refActive_q <= 1'b0; // RQ4
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            refStart_q <= 1'b0;
        else
            refStart_q <= startRef; // RQ2
    end

    // First refresh after reset serves half 0
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            refHalf_q <= 1'b1;
        else if (startRef)
            refHalf_q <= ~refHalf_q; // RQ5
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            refGroup_q <= {GW{1'b0}};
        else if (startRef)
            refGroup_q <= refHalf_q ? grpNow[0] : grpNow[1]; // RQ3
    end
endmodule // dram_refresh_scheduler

/* bench/drs_mem.sv */
// Storage array model that ends each granted access
`timescale 1ns/1ps
module drs_mem (
    input wire mclk, // Clock
    input wire accGrant_q, // Access owns storage
    input wire accWrite, // Writes answer late
    output wire accDone // Access finished
);
    reg [1:0] age_q = 2'h0;
    always @(posedge mclk) age_q <= accGrant_q ? age_q + 2'h1 : 2'h0;
    assign accDone = accGrant_q && age_q == {accWrite, accWrite};
endmodule // drs_mem

/* bench/drs_assertions.sv */
// Port checker for the refresh scheduler
`timescale 1ns/1ps
module drs_chk (
    input logic mclk, // Clock
    input logic rst, // Reset
    input logic accReq, // Request
    input logic accGrant_q, // Grant
    input logic accPend_q, // Held
    input logic refActive_q, // Busy
    input logic refHalf_q, // Half
    input logic refStart_q // Start
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence busyRun; refActive_q [*3] ##1 !refActive_q; endsequence
    busy_len_a: assert property ($rose(refActive_q) |-> busyRun) else $error("len");
    no_grant_a: assert property (!(accGrant_q && refActive_q)) else $error("excl");
    start_edge_a: assert property (refStart_q |-> $rose(refActive_q)) else $error("start");
    half_alt_a: assert property (refStart_q |-> $changed(refHalf_q)) else $error("half");
    half_hold_a: assert property (!refStart_q |-> $stable(refHalf_q)) else $error("hold");
    start_gap_a: assert property (refStart_q |=> !refStart_q [*8]) else $error("gap");
    req_pend_a: assert property (accReq && refActive_q |=> accPend_q) else $error("pend");
    pend_go_a: assert property (accPend_q && !refActive_q |=> accGrant_q) else $error("go");
endmodule // drs_chk

/* bench/tb.sv */
// Bench for the refresh scheduler
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, rst = 1'b1, accReq = 1'b0, accWrite = 1'b0;
    logic accDone, accGrant_q, accPend_q, refActive_q, refHalf_q, refStart_q, memWrite_q;
    logic [6:0] refGroup_q;
    integer failures = 0, comparisons = 0, n;
    dram_refresh_scheduler #(.PERIOD_CYC(40), .BUSY_CYC(3)) uut (
        .mclk(mclk),
        .rst(rst),
        .accReq(accReq),
        .accWrite(accWrite),
        .accDone(accDone),
        .accGrant_q(accGrant_q),
        .accPend_q(accPend_q),
        .refActive_q(refActive_q),
        .refHalf_q(refHalf_q),
        .refGroup_q(refGroup_q),
        .refStart_q(refStart_q),
        .memWrite_q(memWrite_q)
    );
    drs_mem mem (
        .mclk(mclk),
        .accGrant_q(accGrant_q),
        .accWrite(accWrite),
        .accDone(accDone)
    );
    initial forever #20 mclk = ~mclk;
    task chk(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (exp !== got) $display("wrong value %s expected %h seen %h", what, exp, got);
        failures += (exp !== got);
    endtask
    task t_refresh;
        for (int i = 0; i < 4; i++)
        begin
            for (n = 0; n < 60 && refStart_q !== 1'b1; n++) @(negedge mclk);
            chk("half", i % 2, refHalf_q);
            chk("group", i / 2, refGroup_q);
            chk("active", 1, refActive_q);
            @(negedge mclk);
        end
    endtask
    task t_access;
        for (n = 0; n < 60 && refStart_q !== 1'b1; n++) @(negedge mclk);
        @(posedge mclk);
        {accReq, accWrite} <= 2'h3;
        repeat (2) @(negedge mclk);
        chk("pend", 1, accPend_q);
        chk("blocked", 0, accGrant_q);
        for (n = 0; n < 20 && accGrant_q !== 1'b1; n++) @(negedge mclk);
        chk("grant", 1, accGrant_q);
        chk("write", 1, memWrite_q);
    endtask
    task conclude(input integer lost);
        failures += lost;
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial #40000 conclude(1);
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_refresh;
        t_access;
        conclude(0);
    end
endmodule // tb
bind dram_refresh_scheduler drs_chk chkr (
    .mclk(mclk),
    .rst(rst),
    .accReq(accReq),
    .accGrant_q(accGrant_q),
    .accPend_q(accPend_q),
    .refActive_q(refActive_q),
    .refHalf_q(refHalf_q),
    .refStart_q(refStart_q)
);
